// ==== pkg/dmaop_cfg.svh ====
// register map, field positions, reset values and request-word codes of the operation control
`ifndef DMAOP_CFG_SVH
`define DMAOP_CFG_SVH

`define DMAOP_OFS_GLOBAL 8'h00
`define DMAOP_OFS_CHAN_EN 8'h04
`define DMAOP_OFS_SRC 8'h08
`define DMAOP_OFS_TE 8'h0c
`define DMAOP_OFS_COUNT_HI 3'h1

`define DMAOP_BIT_DDT 15
`define DMAOP_BIT_DBL 14
`define DMAOP_BIT_PR_HI 9
`define DMAOP_BIT_PR_LO 8
`define DMAOP_BIT_AE 2
`define DMAOP_BIT_NONMASKABLE_EVENT_FLAG 1
`define DMAOP_BIT_DME 0
`define DMAOP_GLOBAL_RST 32'h0000_0000
`define DMAOP_GLOBAL_RSVD 32'hffff_3cf8
`define DMAOP_CFG_RST 8'h00
`define DMAOP_SRC_RST 16'h0000
`define DMAOP_COUNT_RST 16'h0000

`define DMAOP_DTR_SIZE 63:61
`define DMAOP_DTR_TAG 59:58
`define DMAOP_DTR_KIND 57:56
`define DMAOP_DTR_CNT_HI 55:52
`define DMAOP_SIZE_HI_BANK 3'h5
`define DMAOP_SIZE_QCLR 3'h6
`define DMAOP_KIND_QCLR_ALL 2'h2
`define DMAOP_KIND_QCLR_ONE 2'h3
`define DMAOP_QUEUE_MAX 2'h3

`endif

// ==== pkg/dmaop_pkg.sv ====
// types shared by the operation control block
package dmaop_pkg;
  typedef enum logic [0:0] {
    DMAOP_IDLE = 1'b0,
    DMAOP_ACTIVE = 1'b1
  } dmaop_state_t;

  typedef enum logic [1:0] {
    DMAOP_SRC_AUTO = 2'b00,
    DMAOP_SRC_EXT = 2'b01,
    DMAOP_SRC_PERIPH = 2'b10,
    DMAOP_SRC_NONE = 2'b11
  } dmaop_src_t;

  typedef enum logic [1:0] {
    DMAOP_PRIO_LINEAR = 2'b00,
    DMAOP_PRIO_ONE_LAST = 2'b01,
    DMAOP_PRIO_TWO_FIRST = 2'b10,
    DMAOP_PRIO_ROUND = 2'b11
  } dmaop_prio_t;
endpackage : dmaop_pkg

// ==== rtl/dmaop_arbiter.sv ====
// channel priority selection with fixed orders and round robin
module dmaop_arbiter (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_req,
  input wire logic [1:0] i_mode,
  input wire logic i_done,
  input wire logic [2:0] i_done_ch,
  output logic o_valid,
  output logic [2:0] o_chan
);
  logic [2:0] last;

  function automatic logic [2:0] rank_ch(input logic [1:0] mode, input logic [2:0] k,
                                         input logic [2:0] lst);
    logic [2:0] ch;
    ch = k;
    unique case (dmaop_pkg::dmaop_prio_t'(mode))
      dmaop_pkg::DMAOP_PRIO_LINEAR: ch = k;
      dmaop_pkg::DMAOP_PRIO_ONE_LAST: ch = (k == 3'h0) ? 3'h0 : ((k == 3'h7) ? 3'h1 : 3'(k + 3'h1));
      dmaop_pkg::DMAOP_PRIO_TWO_FIRST: ch = (k == 3'h0) ? 3'h2 : ((k == 3'h1) ? 3'h0 :
                                            ((k == 3'h2) ? 3'h1 : k));
      dmaop_pkg::DMAOP_PRIO_ROUND: ch = 3'(lst + k + 3'h1);
    endcase
    return ch;
  endfunction : rank_ch

  // walk from lowest rank upward so the highest ranked request wins last
  always_comb begin
    logic [2:0] c;
    c = 3'h0;
    o_valid = 1'b0;
    o_chan = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      c = rank_ch(i_mode, 3'(k), last);
      if (i_req[c]) begin
        o_valid = 1'b1;
        o_chan = c;
      end
    end
  end

  // the channel that just finished drops to the bottom; the one after it moves to the top
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      last <= 3'h7;
    end else if (i_done) begin
      last <= i_done_ch;
    end
  end
endmodule : dmaop_arbiter

// ==== rtl/dmaop_chan.sv ====
// per-channel transfer count, transfer-end flag and external request queue
`include "dmaop_cfg.svh"
module dmaop_chan (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_count_wr,
  input wire logic [15:0] i_count_data,
  input wire logic i_te_clr,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic i_qclr,
  input wire logic i_beat,
  output logic [15:0] o_count,
  output logic o_te,
  output logic o_queued
);
  logic [1:0] queue;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_count <= `DMAOP_COUNT_RST;
    end else if (i_count_wr) begin
      o_count <= i_count_data;
    end else if (i_beat && o_count != 16'h0000) begin
      o_count <= o_count - 16'h0001;
    end
  end

  // only the last counted beat ends the channel; an abort never gets here
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_te <= 1'b0;
    end else if (i_beat && o_count == 16'h0001) begin
      o_te <= 1'b1;
    end else if (i_te_clr) begin
      o_te <= 1'b0;
    end
  end

  // a request arriving with a clear still counts, so it is not lost
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      queue <= 2'h0;
    end else if (i_qclr) begin
      queue <= {1'b0, i_push};
    end else if (i_push && !i_pop && queue != `DMAOP_QUEUE_MAX) begin
      queue <= queue + 2'h1;
    end else if (i_pop && !i_push && queue != 2'h0) begin
      queue <= queue - 2'h1;
    end
  end

  assign o_queued = (queue != 2'h0);
endmodule : dmaop_chan

// ==== rtl/dmaop_top.sv ====
// global operation control with on-demand request handling for eight DMA channels
`include "dmaop_cfg.svh"
module dmaop_top (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_nmi,
  input wire logic [1:0] i_external_request_pin_n,
  input wire logic [7:0] i_auto_enable,
  input wire logic [7:0] i_periph_req,
  input wire logic i_dtr_valid,
  input wire logic [63:0] i_dtr_word,
  input wire logic i_beat_done,
  input wire logic i_address_error,
  input wire logic i_bus_free,
  output logic o_xfer_active,
  output logic [2:0] o_xfer_chan,
  output logic o_xfer_dual,
  output logic o_xfer_burst,
  output logic o_ondemand_acknowledge_n,
  output logic [1:0] o_channel_tag,
  output logic o_bus_available_pin,
  output logic o_address_fault_interrupt
);
  logic on_demand_transfer_mode;
  logic channel_count_select;
  logic [1:0] priority_mode;
  logic address_fault_flag;
  logic nonmaskable_event_flag;
  logic master_enable;
  logic ae_seen;
  logic nmi_seen;
  logic [7:0] channel_enable;
  logic [7:0] dual_sel;
  logic [7:0] burst_sel;
  logic [15:0] src_sel;
  logic [1:0] nmi_sync;
  logic nmi_prev;
  logic [1:0] pin_meta;
  logic [1:0] pin_req;
  dmaop_pkg::dmaop_state_t state;
  logic [2:0] act;
  logic [31:0] glob_val;
  logic [31:0] next_rdata;
  logic next_err;
  logic [15:0] count [8];
  logic [7:0] te;
  logic [7:0] queued;
  logic [7:0] elig;
  logic [7:0] push;
  logic [7:0] pop;
  logic [7:0] qclr;
  logic [7:0] beat;
  logic grant_valid;
  logic [2:0] grant_ch;
  logic [2:0] dtr_ch;

  // bus slave: one wait cycle, then the edge with pready high completes
  wire acc = i_psel && i_penable && !o_pready;
  wire done = i_psel && i_penable && o_pready;
  wire wr_go = done && i_pwrite;
  wire rd_glob = done && !i_pwrite && i_paddr == `DMAOP_OFS_GLOBAL;
  wire wr_glob = wr_go && i_paddr == `DMAOP_OFS_GLOBAL;
  wire is_count = i_paddr[7:5] == `DMAOP_OFS_COUNT_HI && i_paddr[1:0] == 2'h0;
  wire nmi_edge = nmi_sync[1] && !nmi_prev;
  wire fault = address_fault_flag || nonmaskable_event_flag;
  wire stop = !master_enable || fault || !channel_enable[act];
  wire ae_set = i_address_error && state == dmaop_pkg::DMAOP_ACTIVE;
  wire last_beat = count[act] == 16'h0001;
  wire grant_ext = src_sel[2 * grant_ch +: 2] == dmaop_pkg::DMAOP_SRC_EXT;
  wire start = state == dmaop_pkg::DMAOP_IDLE && grant_valid && master_enable && !fault;
  wire ack_now = start && on_demand_transfer_mode && grant_ext;
  wire [1:0] dtr_tag = i_dtr_word[`DMAOP_DTR_TAG];
  wire [1:0] dtr_kind = i_dtr_word[`DMAOP_DTR_KIND];
  wire [2:0] dtr_size = i_dtr_word[`DMAOP_DTR_SIZE];
  wire [3:0] dtr_cnt = i_dtr_word[`DMAOP_DTR_CNT_HI];
  wire dtr_on = i_dtr_valid && on_demand_transfer_mode;
  wire dtr_clr_all = dtr_tag == 2'h0 && dtr_kind == `DMAOP_KIND_QCLR_ALL &&
                     dtr_size == `DMAOP_SIZE_QCLR;
  wire dtr_clr_one = dtr_tag == 2'h0 && dtr_kind == `DMAOP_KIND_QCLR_ONE;
  wire dtr_req = dtr_on && !dtr_clr_all && !dtr_clr_one;

  // the first stage only feeds the second
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      nmi_sync <= 2'h0;
      nmi_prev <= 1'b0;
      pin_meta <= 2'h0;
      pin_req <= 2'h0;
    end else begin
      nmi_sync <= {nmi_sync[0], i_nmi};
      nmi_prev <= nmi_sync[1];
      pin_meta <= ~i_external_request_pin_n;
      pin_req <= pin_meta;
    end
  end

  always_comb begin
    glob_val = `DMAOP_GLOBAL_RST;
    glob_val[`DMAOP_BIT_DDT] = on_demand_transfer_mode;
    glob_val[`DMAOP_BIT_DBL] = channel_count_select;
    glob_val[`DMAOP_BIT_PR_HI] = priority_mode[1];
    glob_val[`DMAOP_BIT_PR_LO] = priority_mode[0];
    glob_val[`DMAOP_BIT_AE] = address_fault_flag;
    glob_val[`DMAOP_BIT_NONMASKABLE_EVENT_FLAG] = nonmaskable_event_flag;
    glob_val[`DMAOP_BIT_DME] = master_enable;
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (is_count) begin
      next_rdata = {16'h0000, count[i_paddr[4:2]]};
    end else begin
      unique case (i_paddr)
        `DMAOP_OFS_GLOBAL: next_rdata = glob_val;
        `DMAOP_OFS_CHAN_EN: next_rdata = {8'h00, burst_sel, dual_sel, channel_enable};
        `DMAOP_OFS_SRC: next_rdata = {16'h0000, src_sel};
        `DMAOP_OFS_TE: next_rdata = {24'h00_0000, te};
        default: next_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= acc;
      if (acc) begin
        o_prdata <= i_pwrite ? 32'h0000_0000 : next_rdata;
        o_pslverr <= next_err;
      end else begin
        o_pslverr <= 1'b0;
      end
    end
  end

  // mode bits change only on reset or on a write to the global register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      on_demand_transfer_mode <= 1'b0;
      channel_count_select <= 1'b0;
      priority_mode <= 2'h0;
      master_enable <= 1'b0;
    end else if (wr_glob) begin
      on_demand_transfer_mode <= i_pwdata[`DMAOP_BIT_DDT];
      channel_count_select <= i_pwdata[`DMAOP_BIT_DBL];
      priority_mode <= i_pwdata[`DMAOP_BIT_PR_HI:`DMAOP_BIT_PR_LO];
      master_enable <= i_pwdata[`DMAOP_BIT_DME];
    end
  end

  // a fresh fault in the clearing cycle keeps the flag set
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      address_fault_flag <= 1'b0;
      ae_seen <= 1'b0;
    end else begin
      if (ae_set) begin
        address_fault_flag <= 1'b1;
      end else if (wr_glob && !i_pwdata[`DMAOP_BIT_AE] && ae_seen) begin
        address_fault_flag <= 1'b0;
      end
      if (!address_fault_flag) begin
        ae_seen <= 1'b0;
      end else if (rd_glob && o_prdata[`DMAOP_BIT_AE]) begin
        ae_seen <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      nonmaskable_event_flag <= 1'b0;
      nmi_seen <= 1'b0;
    end else begin
      if (nmi_edge) begin
        nonmaskable_event_flag <= 1'b1;
      end else if (wr_glob && !i_pwdata[`DMAOP_BIT_NONMASKABLE_EVENT_FLAG] && nmi_seen) begin
        nonmaskable_event_flag <= 1'b0;
      end
      if (!nonmaskable_event_flag) begin
        nmi_seen <= 1'b0;
      end else if (rd_glob && o_prdata[`DMAOP_BIT_NONMASKABLE_EVENT_FLAG]) begin
        nmi_seen <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      channel_enable <= `DMAOP_CFG_RST;
      dual_sel <= `DMAOP_CFG_RST;
      burst_sel <= `DMAOP_CFG_RST;
      src_sel <= `DMAOP_SRC_RST;
    end else if (wr_go && i_paddr == `DMAOP_OFS_CHAN_EN) begin
      channel_enable <= i_pwdata[7:0];
      dual_sel <= i_pwdata[15:8];
      burst_sel <= i_pwdata[23:16];
    end else if (wr_go && i_paddr == `DMAOP_OFS_SRC) begin
      src_sel <= i_pwdata[15:0];
    end
  end

  // request word decode; the address and direction fields go to the bus side
  always_comb begin
    dtr_ch = {1'b0, dtr_tag};
    if (channel_count_select && dtr_size == `DMAOP_SIZE_HI_BANK) begin
      dtr_ch = {1'b1, dtr_tag};
    end
  end

  always_comb begin
    for (int c = 0; c < 8; c++) begin
      push[c] = dtr_req && dtr_ch == 3'(c);
      qclr[c] = dtr_on && dtr_clr_all;
      if (dtr_on && dtr_clr_one && channel_count_select && dtr_cnt == 4'(c + 1)) begin
        qclr[c] = 1'b1;
      end
      pop[c] = ack_now && grant_ch == 3'(c);
      beat[c] = state == dmaop_pkg::DMAOP_ACTIVE && !stop && i_beat_done && act == 3'(c);
    end
  end

  always_comb begin
    for (int c = 0; c < 8; c++) begin
      logic req;
      req = 1'b0;
      unique case (dmaop_pkg::dmaop_src_t'(src_sel[2 * c +: 2]))
        dmaop_pkg::DMAOP_SRC_AUTO: req = i_auto_enable[c];
        dmaop_pkg::DMAOP_SRC_EXT: req = on_demand_transfer_mode ? queued[c] :
                                        (c < 2 && pin_req[c[0]]);
        dmaop_pkg::DMAOP_SRC_PERIPH: req = i_periph_req[c];
        dmaop_pkg::DMAOP_SRC_NONE: req = 1'b0;
      endcase
      elig[c] = master_enable && channel_enable[c] && !te[c] && !fault &&
                count[c] != 16'h0000 && req;
    end
  end

  for (genvar g = 0; g < 8; g++) begin : g_chan
    dmaop_chan u_chan (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_count_wr(wr_go && is_count && i_paddr[4:2] == 3'(g)),
      .i_count_data(i_pwdata[15:0]),
      .i_te_clr(wr_go && i_paddr == `DMAOP_OFS_TE && i_pwdata[g]),
      .i_push(push[g]),
      .i_pop(pop[g]),
      .i_qclr(qclr[g]),
      .i_beat(beat[g]),
      .o_count(count[g]),
      .o_te(te[g]),
      .o_queued(queued[g])
    );
  end

  dmaop_arbiter u_arb (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_req(elig),
    .i_mode(priority_mode),
    .i_done(|beat),
    .i_done_ch(act),
    .o_valid(grant_valid),
    .o_chan(grant_ch)
  );

  // cycle steal gives the bus back after every beat; burst holds it to the end
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state <= dmaop_pkg::DMAOP_IDLE;
      act <= 3'h0;
      o_xfer_active <= 1'b0;
    end else begin
      unique case (state)
        dmaop_pkg::DMAOP_IDLE: begin
          if (start) begin
            state <= dmaop_pkg::DMAOP_ACTIVE;
            act <= grant_ch;
            o_xfer_active <= 1'b1;
          end
        end
        dmaop_pkg::DMAOP_ACTIVE: begin
          if (stop || (i_beat_done && (last_beat || !burst_sel[act]))) begin
            state <= dmaop_pkg::DMAOP_IDLE;
            o_xfer_active <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_xfer_chan <= 3'h0;
      o_xfer_dual <= 1'b0;
      o_xfer_burst <= 1'b0;
    end else if (start) begin
      o_xfer_chan <= grant_ch;
      o_xfer_dual <= dual_sel[grant_ch];
      o_xfer_burst <= burst_sel[grant_ch];
    end
  end

  // the acknowledge is a single cycle, so the pin falls back to bus state next
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_ondemand_acknowledge_n <= 1'b1;
      o_channel_tag <= 2'h0;
      o_bus_available_pin <= 1'b0;
    end else begin
      o_ondemand_acknowledge_n <= !ack_now;
      if (ack_now) begin
        o_channel_tag <= grant_ch[1:0];
      end
      if (ack_now && channel_count_select) begin
        o_bus_available_pin <= !grant_ch[2];
      end else begin
        o_bus_available_pin <= i_bus_free;
      end
    end
  end

  assign o_address_fault_interrupt = address_fault_flag;

  default clocking dmaop_cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  reset_clears_a: assert property (@(posedge i_sys_clk) disable iff (1'b0)
    i_sys_rst |=> glob_val == `DMAOP_GLOBAL_RST) else $error("global not cleared");
  reserved_zero_a: assert property ((glob_val & `DMAOP_GLOBAL_RSVD) == 32'h0)
    else $error("reserved bit set");
  four_chan_a: assert property ((dtr_req && !channel_count_select) |-> !dtr_ch[2])
    else $error("high channel accepted");
  chan_select_a: assert property ((dtr_req && channel_count_select) |->
    dtr_ch == {dtr_size == `DMAOP_SIZE_HI_BANK, dtr_tag}) else $error("bad target");
  fixed_order_a: assert property ((start && priority_mode == 2'h0) |->
    (elig & ((8'h01 << grant_ch) - 8'h01)) == 8'h00) else $error("order broken");
  fault_halt_a: assert property ((ae_set || nmi_edge) |=> ##1 !o_xfer_active)
    else $error("transfer not halted");
  one_ignored_a: assert property ((wr_glob && i_pwdata[`DMAOP_BIT_AE] && !address_fault_flag
    && !ae_set) |=> !address_fault_flag) else $error("flag written to one");
  nmi_sets_a: assert property ($rose(nmi_sync[1]) |=> nonmaskable_event_flag)
    else $error("nmi flag missed");
  dme_halt_a: assert property ((!master_enable && state == dmaop_pkg::DMAOP_ACTIVE)
    |=> !o_xfer_active) else $error("disable ignored");
  id2_out_a: assert property ((ack_now && channel_count_select) |=>
    (!o_ondemand_acknowledge_n && o_bus_available_pin == !o_xfer_chan[2]))
    else $error("third bit wrong");
  te_only_end_a: assert property ((state == dmaop_pkg::DMAOP_ACTIVE && stop) |=>
    $stable(te)) else $error("end flag on abort");

  burst_run_c: cover property (start ##1 i_beat_done [*3]);
  ondemand_ack_c: cover property (ack_now ##1 !o_ondemand_acknowledge_n);
  queue_clear_c: cover property (dtr_on && dtr_clr_one && channel_count_select);
  round_robin_c: cover property (start && priority_mode == 2'h3);
endmodule : dmaop_top

// ==== verif/dmaop_ext_dev.sv ====
// external requester model that forms and presents on-demand request words
module dmaop_ext_dev (
  input wire logic i_sys_clk,
  output logic o_dtr_valid,
  output logic [63:0] o_dtr_word
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_dtr_valid = 1'h0;
    o_dtr_word = 64'h0;
  end
  task automatic send(input logic [2:0] sz, input logic [1:0] tg, input logic [1:0] kd,
                      input logic [3:0] cn);
    logic [63:0] w;
    w = {sz, 1'h0, tg, kd, cn, 4'h0, 16'h0000, 32'h0000_1000};
    @(posedge i_sys_clk);
    o_dtr_valid <= 1'h1;
    o_dtr_word <= w;
    @(posedge i_sys_clk);
    o_dtr_valid <= 1'h0;
    // a released word must not look like the last one
    o_dtr_word <= ~w;
  endtask : send
endmodule : dmaop_ext_dev

// ==== verif/dmaop_top_tb.sv ====
// self-checking bench for the operation control block
module dmaop_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [7:0] am;
    logic od;
    logic [2:0] sz;
    logic [1:0] tg;
    logic [2:0] ch;
    logic bus;
  } dmaop_row_t;
  localparam dmaop_row_t rows [7] = '{
    '{16'h0000, 8'h06, 1'h0, 3'h0, 2'h0, 3'h1, 1'h0},
    '{16'h0100, 8'h06, 1'h0, 3'h0, 2'h0, 3'h2, 1'h0},
    '{16'h0200, 8'h07, 1'h0, 3'h0, 2'h0, 3'h2, 1'h0},
    '{16'h0300, 8'h82, 1'h0, 3'h0, 2'h0, 3'h1, 1'h0},
    '{16'h8000, 8'h00, 1'h1, 3'h0, 2'h2, 3'h2, 1'h0},
    '{16'hc000, 8'h00, 1'h1, 3'h5, 2'h3, 3'h7, 1'h0},
    '{16'hc000, 8'h00, 1'h1, 3'h2, 2'h1, 3'h1, 1'h1}};
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic nmi = 1'h0, beat = 1'h0, aerr = 1'h0;
  logic [7:0] paddr = 8'h0, am = 8'h0;
  logic [1:0] pin_n = 2'h3;
  logic [31:0] pwd = 32'h0, rd, prdata;
  logic pready, pslverr, er, act, dual, burst, ack_n, bus, irq, seen, dv;
  logic [2:0] chn;
  logic [1:0] tag;
  logic [63:0] dw;
  int n_fail = 0;
  int num_checks = 0;
  dmaop_top dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_nmi(nmi), .i_external_request_pin_n(pin_n), .i_auto_enable(am),
    .i_periph_req(8'h00), .i_dtr_valid(dv), .i_dtr_word(dw), .i_beat_done(beat),
    .i_address_error(aerr), .i_bus_free(1'h1), .o_xfer_active(act), .o_xfer_chan(chn),
    .o_xfer_dual(dual), .o_xfer_burst(burst), .o_ondemand_acknowledge_n(ack_n),
    .o_channel_tag(tag), .o_bus_available_pin(bus), .o_address_fault_interrupt(irq));
  dmaop_ext_dev ext (.i_sys_clk(clk), .o_dtr_valid(dv), .o_dtr_word(dw));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    // wait for ready as sampled at the edge; the watchdog bounds it
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask : rdr
  task automatic wst();
    seen = 1'h0;
    repeat (30) begin
      @(posedge clk);
      if (act === 1'h1) begin
        seen = 1'h1;
        break;
      end
    end
  endtask : wst
  task automatic prep(input logic [31:0] src);
    wr(8'h04, 32'h0000_00ff);
    wr(8'h0c, 32'h0000_00ff);
    wr(8'h08, src);
    for (int c = 0; c < 8; c++) wr(8'h20 + 8'(c * 4), 32'h0000_0001);
  endtask : prep
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      prep(rows[i].od ? 32'h0000_5555 : 32'h0);
      wr(8'h00, {16'h0, rows[i].ctrl});
      am <= rows[i].am;
      if (rows[i].od) ext.send(rows[i].sz, rows[i].tg, 2'h0, 4'h0);
      wr(8'h00, {16'h0, rows[i].ctrl | 16'h0001});
      wst();
      chk("start", seen, 1'h1);
      chk("chan", chn, rows[i].ch);
      if (rows[i].od) chk("ack", {ack_n, tag}, {1'h0, rows[i].ch[1:0]});
      if (rows[i].ctrl[14]) chk("bus", bus, rows[i].bus);
      am <= 8'h00;
      wr(8'h00, 32'h0);
    end
    prep(32'h0);
    wr(8'h2c, 32'h0000_0002);
    wr(8'h00, 32'h0000_0001);
    am <= 8'h01;
    wst();
    chk("ch0", chn, 3'h0);
    @(posedge clk) beat <= 1'h1;
    @(posedge clk) beat <= 1'h0;
    am <= 8'h09;
    repeat (3) @(posedge clk);
    wst();
    chk("ch3", chn, 3'h3);
    @(posedge clk) aerr <= 1'h1;
    @(posedge clk) aerr <= 1'h0;
    repeat (3) @(posedge clk);
    chk("fault", {irq, act}, 2'h2);
    rdr(8'h0c);
    chk("te", rd, 32'h1);
    rdr(8'h00);
    chk("flag", rd, 32'h5);
    wr(8'h00, 32'h1);
    rdr(8'h00);
    chk("clr", {irq, rd}, 33'h1);
    am <= 8'h00;
    prep(32'h0000_5555);
    wr(8'h00, 32'h0000_c001);
    @(posedge clk) nmi <= 1'h1;
    repeat (4) @(posedge clk);
    nmi <= 1'h0;
    repeat (4) @(posedge clk);
    wr(8'h00, 32'h0000_c001);
    rdr(8'h00);
    chk("nmi", rd, 32'h0000_c003);
    ext.send(3'h5, 2'h1, 2'h0, 4'h0);
    wst();
    chk("hold", seen, 1'h0);
    wr(8'h00, 32'h0000_c001);
    wst();
    chk("go", {seen, chn}, 4'hd);
    wr(8'h00, 32'h0000_c000);
    prep(32'h0000_5555);
    ext.send(3'h5, 2'h1, 2'h0, 4'h0);
    ext.send(3'h5, 2'h2, 2'h0, 4'h0);
    ext.send(3'h0, 2'h0, 2'h3, 4'h6);
    wr(8'h00, 32'h0000_c001);
    wst();
    chk("qone", {chn, bus}, 4'hc);
    wr(8'h00, 32'h0000_c000);
    ext.send(3'h0, 2'h1, 2'h0, 4'h0);
    ext.send(3'h0, 2'h2, 2'h0, 4'h0);
    ext.send(3'h6, 2'h0, 2'h2, 4'h0);
    wr(8'h00, 32'h0000_c001);
    wst();
    chk("qall", seen, 1'h0);
    // normal mode: the pin of channel 1 drives it through the synchroniser
    wr(8'h00, 32'h0);
    prep(32'h0000_0004);
    pin_n <= 2'h1;
    wr(8'h00, 32'h1);
    wst();
    chk("pin", {seen, chn}, 4'h9);
    pin_n <= 2'h3;
    wr(8'h00, 32'h0);
    @(posedge clk) rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rdr(8'h00);
    chk("rst", rd, 32'h0);
    rdr(8'h0c);
    chk("rte", rd, 32'h0);
    wr(8'h00, 32'hffff_ffff);
    rdr(8'h00);
    chk("rsvd", rd, 32'h0000_c301);
    // round robin: after a beat on channel 0, channel 1 must win over it
    prep(32'h0);
    wr(8'h20, 32'h0000_0002);
    am <= 8'h03;
    wst();
    chk("rr0", chn, 3'h0);
    @(posedge clk) beat <= 1'h1;
    @(posedge clk) beat <= 1'h0;
    wst();
    chk("rr1", chn, 3'h1);
    am <= 8'h00;
    rdr(8'h80);
    chk("unmap", {er, rd}, 33'h1_0000_0000);
    wr(8'h00, 32'h0);
    give_verdict();
  end
endmodule : dmaop_top_tb
